// ==== timer_irq_pkg.sv ====
// Package with register map, field positions and bus carrier types for the timer/irq control block
package timer_irq_pkg;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [7:0] CTRL_ADDR = 8'h88;
  localparam logic [7:0] MODE_ADDR = 8'h89;
  localparam logic [7:0] EVT_STATUS_ADDR = 8'h8C;
  localparam logic [7:0] EVT_CLEAR_ADDR = 8'h90;
  localparam logic [7:0] EVT_ENABLE_ADDR = 8'h94;
  // Control byte fields
  localparam int TF1_BIT = 7;
  localparam int TR1_BIT = 6;
  localparam int TF0_BIT = 5;
  localparam int TR0_BIT = 4;
  localparam int IE1_BIT = 3;
  localparam int IT1_BIT = 2;
  localparam int IE0_BIT = 1;
  localparam int IT0_BIT = 0;
  // Mode register gate bits
  localparam int GATE1_BIT = 7;
  localparam int TIMER0_PIN_GATE_OPTION_BIT = 3;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] EVT_RESET = 4'h0;
  // Read data for unmapped addresses
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // Event status layout: bit0 t0 ovf, bit1 t1 ovf, bit2 irq0, bit3 irq1
  localparam int EVT_W = 4;

  // Avalon-MM request carrier
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avm_req_s;

  // Slave answer states
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_e;
endpackage : timer_irq_pkg

// ==== ext_irq_detect.sv ====
// Synchroniser and trigger detector for one external interrupt pin
`timescale 1ns/10ps
module ext_irq_detect (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic pin_in,
  input wire logic edge_mode_in,
  output logic level_out,
  output logic trigger_out
);
  // Two-stage synchroniser; only sync_b is ever looked at
  logic sync_a;
  logic sync_b;
  // Previous synchronised sample for edge detection
  logic prev;

  // Synchronise pin, reset high as an idle pin
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      prev <= 1'b1;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  assign level_out = sync_b;
  // Falling edge is high then low; level mode requests while low
  assign trigger_out = edge_mode_in ? (prev & ~sync_b) : ~sync_b;
endmodule : ext_irq_detect

// ==== timer_irq_control.sv ====
// Timer run/overflow control byte with external interrupt detection and Avalon-MM slave
`timescale 1ns/10ps
module timer_irq_control
  import timer_irq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Timer side
  input wire logic timer0_overflow_in,
  input wire logic timer1_overflow_in,
  output logic timer0_count_enable_out,
  output logic timer1_count_enable_out,
  // Interrupt controller acknowledges (one-cycle pulses)
  input wire logic timer0_irq_ack_in,
  input wire logic timer1_irq_ack_in,
  input wire logic ext_irq0_ack_in,
  input wire logic ext_irq1_ack_in,
  // External interrupt pins
  input wire logic ext_irq_pin0_in,
  input wire logic ext_irq_pin1_in,
  // Control byte as seen by the interrupt controller
  output logic [7:0] timer_irq_control_out,
  // Level interrupt for enabled events
  output logic irq_out
);
  // Control byte and mode register
  logic [7:0] timer_irq_control;
  logic [7:0] timer_mode_reg;
  // Sticky event status and enable
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable;
  // Bus slave state and captured request
  bus_state_e bus_state;
  avm_req_s req;
  // Write strobes, valid only in the acknowledge cycle
  logic wr_ctrl;
  logic wr_mode;
  logic wr_clear;
  logic wr_enable;
  // Pin detector outputs
  logic pin0_level;
  logic pin1_level;
  logic pin0_trig;
  logic pin1_trig;
  // Combined next values
  logic [7:0] next_ctrl;
  logic [EVT_W-1:0] evt_set;
  logic next_run0;
  logic next_run1;

  // Pin 0 detector, trigger type from bit 0
  // pin0 trigger select
  ext_irq_detect u_pin0 (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .pin_in(ext_irq_pin0_in),
    .edge_mode_in(timer_irq_control[IT0_BIT]),
    .level_out(pin0_level),
    .trigger_out(pin0_trig)
  );

  // Pin 1 detector, trigger type from bit 2
  // pin1 trigger select
  ext_irq_detect u_pin1 (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .pin_in(ext_irq_pin1_in),
    .edge_mode_in(timer_irq_control[IT1_BIT]),
    .level_out(pin1_level),
    .trigger_out(pin1_trig)
  );

  // Capture the request, answer one cycle later; waitrequest is high while idle
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_state <= BUS_IDLE;
      req <= '0;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (avs_read_in || avs_write_in) begin
            bus_state <= BUS_ACK;
            req.address <= avs_address_in;
            req.read <= avs_read_in;
            req.write <= avs_write_in;
            req.writedata <= avs_writedata_in;
          end
        end
        BUS_ACK: begin
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest drops in the cycle the answer is valid
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !(bus_state == BUS_IDLE && (avs_read_in || avs_write_in));
    end
  end

  // Writes land at the edge where waitrequest is sampled low
  assign wr_ctrl = (bus_state == BUS_ACK) && req.write && req.address == CTRL_ADDR;
  assign wr_mode = (bus_state == BUS_ACK) && req.write && req.address == MODE_ADDR;
  assign wr_clear = (bus_state == BUS_ACK) && req.write && req.address == EVT_CLEAR_ADDR;
  assign wr_enable = (bus_state == BUS_ACK) && req.write && req.address == EVT_ENABLE_ADDR;

  // Read data registered with the answer; unmapped reads give zero
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_readdata_out <= UNMAPPED_DATA;
    end else if (bus_state == BUS_IDLE && avs_read_in) begin
      case (avs_address_in)
        CTRL_ADDR: avs_readdata_out <= {24'h00_0000, timer_irq_control};
        MODE_ADDR: avs_readdata_out <= {24'h00_0000, timer_mode_reg};
        EVT_STATUS_ADDR: avs_readdata_out <= {28'h000_0000, evt_status};
        EVT_ENABLE_ADDR: avs_readdata_out <= {28'h000_0000, evt_enable};
        default: avs_readdata_out <= UNMAPPED_DATA;
      endcase
    end
  end

  // Next control byte: software write, then acknowledge clears, then hardware sets win
  always_comb begin
    next_ctrl = timer_irq_control;
    if (wr_ctrl) begin
      next_ctrl = req.writedata[7:0];
    end
    if (timer0_irq_ack_in) begin
      next_ctrl[TF0_BIT] = 1'b0;
    end
    if (timer1_irq_ack_in) begin
      next_ctrl[TF1_BIT] = 1'b0;
    end
    if (ext_irq0_ack_in) begin
      next_ctrl[IE0_BIT] = 1'b0;
    end
    if (ext_irq1_ack_in) begin
      next_ctrl[IE1_BIT] = 1'b0;
    end
    if (timer0_overflow_in) begin
      next_ctrl[TF0_BIT] = 1'b1;
    end
    if (timer1_overflow_in) begin
      next_ctrl[TF1_BIT] = 1'b1;
    end
    if (pin0_trig) begin
      next_ctrl[IE0_BIT] = 1'b1;
    end
    if (pin1_trig) begin
      next_ctrl[IE1_BIT] = 1'b1;
    end
  end

  // Control byte register; set beats clear so no event is lost
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timer_irq_control <= CTRL_RESET;
    end else begin
      timer_irq_control <= next_ctrl;
    end
  end

  // Mode register, only gate bits steer this block
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timer_mode_reg <= MODE_RESET;
    end else if (wr_mode) begin
      timer_mode_reg <= req.writedata[7:0];
    end
  end

  // Count enables from run bit and optional pin gate
  // run bit gates counting
  assign next_run0 = timer_irq_control[TR0_BIT] && (!timer_mode_reg[TIMER0_PIN_GATE_OPTION_BIT] || pin0_level);
  assign next_run1 = timer_irq_control[TR1_BIT] && (!timer_mode_reg[GATE1_BIT] || pin1_level);

  // Registered so outputs come from flip-flops; count enables lag one cycle, control byte copy loads next_ctrl with no lag
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timer0_count_enable_out <= 1'b0;
      timer1_count_enable_out <= 1'b0;
      timer_irq_control_out <= CTRL_RESET;
    end else begin
      timer0_count_enable_out <= next_run0;
      timer1_count_enable_out <= next_run1;
      timer_irq_control_out <= next_ctrl;
    end
  end

  // Each event, as it stands this cycle, into the sticky status
  assign evt_set = {pin1_trig, pin0_trig, timer1_overflow_in, timer0_overflow_in};

  // Sticky status: a set in the clear cycle wins
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      evt_status <= EVT_RESET;
    end else begin
      evt_status <= (evt_status & ~(wr_clear ? req.writedata[EVT_W-1:0] : EVT_RESET)) | evt_set;
    end
  end

  // Interrupt enable register
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      evt_enable <= EVT_RESET;
    end else if (wr_enable) begin
      evt_enable <= req.writedata[EVT_W-1:0];
    end
  end

  // Level interrupt, registered
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_status & evt_enable);
    end
  end

  // Assertions
  sequence s_ovf0;
    timer0_overflow_in;
  endsequence

  chk_ovf0_sets_flag: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    s_ovf0 |=> timer_irq_control[TF0_BIT])
    else $error("timer0 overflow did not set flag");

  chk_ovf1_sets_flag: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    timer1_overflow_in |=> timer_irq_control[TF1_BIT])
    else $error("timer1 overflow did not set flag");

  chk_ack_clears_tf0: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    timer0_irq_ack_in && !timer0_overflow_in |=> !timer_irq_control[TF0_BIT])
    else $error("timer0 ack did not clear flag");

  chk_ack_clears_ie1: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    ext_irq1_ack_in && !pin1_trig |=> !timer_irq_control[IE1_BIT])
    else $error("irq1 ack did not clear request");

  chk_run_stops: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    !timer_irq_control[TR0_BIT] |=> !timer0_count_enable_out)
    else $error("timer0 enabled while run bit clear");

  chk_gate_pin_low: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    timer_mode_reg[TIMER0_PIN_GATE_OPTION_BIT] && !pin0_level |=> !timer0_count_enable_out)
    else $error("gated timer0 ran with pin low");

  chk_edge_pin0: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    timer_irq_control[IT0_BIT] && $fell(pin0_level) |=> timer_irq_control[IE0_BIT])
    else $error("pin0 falling edge not latched");

  chk_level_pin1: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    !timer_irq_control[IT1_BIT] && !pin1_level |=> timer_irq_control[IE1_BIT])
    else $error("pin1 low level not latched");

  chk_edge_needs_high: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    pin0_trig && timer_irq_control[IT0_BIT] |-> $past(pin0_level))
    else $error("edge trigger without prior high");

  chk_bus_answers: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    bus_state == BUS_IDLE && avs_write_in |=> !avs_waitrequest_out)
    else $error("bus answer not in one cycle");
endmodule : timer_irq_control

// ==== irq_ack_model.sv ====
// Interrupt controller model that acknowledges pending flags of the control byte
`timescale 1ns/10ps
module irq_ack_model (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] ctrl_in, // Control byte from the block
  input wire logic [3:0] ack_en_in, // Per source: t0, t1, pin0, pin1
  output logic [3:0] ack_out // One-cycle acknowledge pulses
);
  logic [3:0] pending; // Flags in acknowledge order
  assign pending = {ctrl_in[3], ctrl_in[1], ctrl_in[7], ctrl_in[5]};
  // acknowledge pending flags
  // Pulses never stand two cycles, so a level request shows its re-set
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_out <= 4'h0;
    end else begin
      ack_out <= pending & ack_en_in & ~ack_out;
    end
  end
endmodule : irq_ack_model

// ==== timer_irq_control_tb_top.sv ====
// Self-checking bench for the timer run and external interrupt control byte
`timescale 1ns/10ps
module timer_irq_control_tb_top
  import timer_irq_pkg::*;
  ;
  logic clk, rst_n, rd, wr, ov0, ov1, pin0, pin1, wait_rq, en0, en1, irq;
  logic [7:0] addr, ctrl;
  logic [31:0] wdata, rdata, q; // q holds the last read data
  logic [3:0] ack, ack_en;
  int n_mismatch, comparisons;

  timer_irq_control u_dut (.core_clk_in(clk), .arst_n_in(rst_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_rq), .timer0_overflow_in(ov0), .timer1_overflow_in(ov1),
    .timer0_count_enable_out(en0), .timer1_count_enable_out(en1), .timer0_irq_ack_in(ack[0]),
    .timer1_irq_ack_in(ack[1]), .ext_irq0_ack_in(ack[2]), .ext_irq1_ack_in(ack[3]),
    .ext_irq_pin0_in(pin0), .ext_irq_pin1_in(pin1), .timer_irq_control_out(ctrl), .irq_out(irq));
  irq_ack_model u_ack (.core_clk_in(clk), .arst_n_in(rst_n), .ctrl_in(ctrl),
    .ack_en_in(ack_en), .ack_out(ack));

  // Free-running core clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // One access; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (!wait_rq) break;
    end
    // A hung slave ends the run here
    if (i == 50) begin
      n_mismatch++;
      conclude();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd_chk

  // Single-cycle overflow pulses from the timers
  task automatic ovf(input logic [1:0] which);
    {ov1, ov0} <= which;
    @(posedge clk);
    {ov1, ov0} <= 2'b00;
  endtask : ovf

  task automatic t_reset();
    chk(32'({en1, en0, irq}), 32'h0000_0000);
    rd_chk(CTRL_ADDR, 32'h0000_0000);
    rd_chk(MODE_ADDR, 32'h0000_0000);
    rd_chk(EVT_STATUS_ADDR, 32'h0000_0000);
    rd_chk(8'hA0, 32'h0000_0000);
  endtask : t_reset

  task automatic t_run();
    bus(1'b1, CTRL_ADDR, 32'h0000_0050);
    idle(3);
    chk(32'({en1, en0}), 32'h0000_0003);
    rd_chk(CTRL_ADDR, 32'h0000_0050);
    bus(1'b1, CTRL_ADDR, 32'h0000_0010);
    idle(3);
    chk(32'({en1, en0}), 32'h0000_0001);
    bus(1'b1, CTRL_ADDR, 32'h0000_0000);
    idle(3);
    chk(32'({en1, en0}), 32'h0000_0000);
  endtask : t_run

  task automatic t_ovf();
    ovf(2'b01);
    idle(2);
    rd_chk(CTRL_ADDR, 32'h0000_0020);
    bus(1'b1, CTRL_ADDR, 32'h0000_0000);
    rd_chk(CTRL_ADDR, 32'h0000_0000);
    ovf(2'b10);
    idle(2);
    rd_chk(CTRL_ADDR, 32'h0000_0080);
    ack_en <= 4'h2;
    idle(4);
    ack_en <= 4'h0;
    rd_chk(CTRL_ADDR, 32'h0000_0000);
  endtask : t_ovf

  // Sticky status, enable, write-one clear and refused accesses
  task automatic t_irq();
    rd_chk(EVT_STATUS_ADDR, 32'h0000_0003);
    bus(1'b1, EVT_ENABLE_ADDR, 32'h0000_0001);
    idle(3);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, EVT_CLEAR_ADDR, 32'h0000_0001);
    idle(3);
    chk(32'(irq), 32'h0000_0000);
    rd_chk(EVT_STATUS_ADDR, 32'h0000_0002);
    bus(1'b1, EVT_STATUS_ADDR, 32'h0000_000F);
    rd_chk(EVT_CLEAR_ADDR, 32'h0000_0000);
    rd_chk(EVT_STATUS_ADDR, 32'h0000_0002);
    bus(1'b1, EVT_CLEAR_ADDR, 32'h0000_000F);
    rd_chk(EVT_STATUS_ADDR, 32'h0000_0000);
    rd_chk(EVT_ENABLE_ADDR, 32'h0000_0001);
  endtask : t_irq

  task automatic t_edge();
    bus(1'b1, CTRL_ADDR, 32'h0000_0005);
    pin0 <= 1'b0;
    idle(6);
    rd_chk(CTRL_ADDR, 32'h0000_0007);
    chk(32'(ctrl), 32'h0000_0007);
    pin1 <= 1'b0;
    idle(6);
    rd_chk(CTRL_ADDR, 32'h0000_000F);
    ack_en <= 4'hC;
    idle(4);
    ack_en <= 4'h0;
    // Pins still low: an edge request must not come back
    rd_chk(CTRL_ADDR, 32'h0000_0005);
    chk(32'(ctrl), 32'h0000_0005);
    {pin1, pin0} <= 2'b11;
    idle(4);
  endtask : t_edge

  task automatic t_level();
    bus(1'b1, CTRL_ADDR, 32'h0000_0000);
    pin1 <= 1'b0;
    idle(5);
    rd_chk(CTRL_ADDR, 32'h0000_0008);
    ack_en <= 4'h8;
    idle(4);
    rd_chk(CTRL_ADDR, 32'h0000_0008);
    pin1 <= 1'b1;
    idle(6);
    ack_en <= 4'h0;
    rd_chk(CTRL_ADDR, 32'h0000_0000);
  endtask : t_level

  task automatic t_gate();
    bus(1'b1, MODE_ADDR, 32'h0000_0088);
    bus(1'b1, CTRL_ADDR, 32'h0000_0050);
    idle(3);
    chk(32'({en1, en0}), 32'h0000_0003);
    pin0 <= 1'b0;
    idle(5);
    chk(32'({en1, en0}), 32'h0000_0002);
    rd_chk(CTRL_ADDR, 32'h0000_0052);
    pin0 <= 1'b1;
    idle(5);
    chk(32'({en1, en0}), 32'h0000_0003);
  endtask : t_gate

  // Main sequence: 20 cycles of reset, then every scenario in turn
  initial begin
    {rd, wr, ov0, ov1, addr, wdata, ack_en} = '0;
    {rst_n, pin1, pin0} = 3'b011;
    n_mismatch = 0;
    comparisons = 0;
    idle(20);
    rst_n <= 1'b1;
    t_reset();
    t_run();
    t_ovf();
    t_irq();
    t_edge();
    t_level();
    t_gate();
    conclude();
  end
endmodule : timer_irq_control_tb_top
